// ---- hw/rfia_map.svh ----
/*
 Register offsets, bit positions, reset values and vector numbers
 of the radio interrupt aggregator. Assumes byte addresses on APB.
*/
`ifndef RFIA_MAP_SVH
`define RFIA_MAP_SVH

`define RFIA_OFS_EVT_FLAGS_LOW 8'h00
`define RFIA_OFS_EVT_FLAGS_HIGH 8'h04
`define RFIA_OFS_ERR_FLAGS 8'h08
`define RFIA_OFS_EVT_MASK_LOW 8'h0C
`define RFIA_OFS_EVT_MASK_HIGH 8'h10
`define RFIA_OFS_ERR_MASK 8'h14
`define RFIA_OFS_CPU_IE 8'h18
`define RFIA_OFS_CPU_IF 8'h1C

`define RFIA_VEC_ERR 1'b0
`define RFIA_VEC_EVT 1'b1
`define RFIA_VNUM_ERR 4'h0
`define RFIA_VNUM_EVT 4'hC

`define RFIA_ERR_RX_OVF 0
`define RFIA_ERR_RX_UNF 1
`define RFIA_ERR_TX_OVF 2
`define RFIA_ERR_TX_UNF 3

`define RFIA_RST_BYTE 8'h00
`define RFIA_RST_PAIR 2'h0

`endif

// ---- hw/rfia_pkg.sv ----
/*
 Types of the radio interrupt aggregator.
 Assumes rfia_map.svh supplies the numeric constants.
*/
package rfia_pkg;
    typedef logic [3:0] rfia_vnum_t;

    typedef struct packed {
        logic [7:0] flg_lo;
        logic [7:0] flg_hi;
        logic [7:0] err;
        logic [7:0] msk_lo;
        logic [7:0] msk_hi;
        logic [7:0] err_m;
        logic [1:0] ie;
        logic [1:0] mf;
        logic [7:0] src_lo_q;
        logic [7:0] src_hi_q;
        logic [1:0] req;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
        logic irq_err;
        logic irq_evt;
        logic [3:0] vnum;
    } rfia_state_t;
endpackage

// ---- hw/rfia_top.sv ----
/*
 Radio interrupt aggregator: core flags, masks, two CPU vectors with
 main flags and enables, reached over APB.
 Assumes radio sources and buffer strobes are synchronous to mclk.
*/
// Functional notes
// - Radio reaches the CPU through two vectors, numbered 0 and 12.
// - Errors go on the error vector, normal events on the event vector.
// - Event flags set on a 0 to 1 change of their source.
// - Each source has its own flag and mask bit, in three register pairs.
// - Flags keep updating while masked; masks only gate forwarding.
// - Each vector has one CPU enable bit and one main flag.
// - Core flag and main flag must both be cleared; flags hold until then.
// - Clearing a core flag with other unmasked flags pending sets main flag again.
// - A main flag still set keeps the interrupt requested.
// - Write to full or read from empty buffer sets an error flag.
`timescale 1ns/1ps
`default_nettype none
`include "rfia_map.svh"

module rfia_top (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] event_src_low,
    input wire logic [7:0] event_src_high,
    input wire logic [7:4] error_src,
    input wire logic rx_buf_wr,
    input wire logic rx_buf_rd,
    input wire logic rx_buf_full,
    input wire logic rx_buf_empty,
    input wire logic tx_buf_wr,
    input wire logic tx_buf_rd,
    input wire logic tx_buf_full,
    input wire logic tx_buf_empty,
    output logic radio_error_vector,
    output logic radio_event_vector,
    output logic irq,
    output rfia_pkg::rfia_vnum_t irq_vector_num
);
    import rfia_pkg::*;

    rfia_state_t s;
    rfia_state_t n;

    logic acc;
    logic wr;
    logic [7:0] wb;
    logic hit;
    logic [7:0] clr_lo;
    logic [7:0] clr_hi;
    logic [7:0] clr_err;
    logic [1:0] clr_mf;
    logic [7:0] rise_lo;
    logic [7:0] rise_hi;
    logic [7:0] err_set;
    logic req_err;
    logic req_evt;
    logic [1:0] core_clr;
    logic [1:0] set_mf;
    logic [31:0] rd_mux;

    // Write lands at the edge where pready is sampled high
    assign acc = psel & penable;
    assign wr = acc & s.pready & pwrite;
    assign wb = pwdata[7:0];

    always_comb begin
        hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            `RFIA_OFS_EVT_FLAGS_LOW: rd_mux[7:0] = s.flg_lo;
            `RFIA_OFS_EVT_FLAGS_HIGH: rd_mux[7:0] = s.flg_hi;
            `RFIA_OFS_ERR_FLAGS: rd_mux[7:0] = s.err;
            `RFIA_OFS_EVT_MASK_LOW: rd_mux[7:0] = s.msk_lo;
            `RFIA_OFS_EVT_MASK_HIGH: rd_mux[7:0] = s.msk_hi;
            `RFIA_OFS_ERR_MASK: rd_mux[7:0] = s.err_m;
            `RFIA_OFS_CPU_IE: rd_mux[1:0] = s.ie;
            `RFIA_OFS_CPU_IF: rd_mux[1:0] = s.mf;
            default: hit = 1'b0;
        endcase
    end

    // Write-one-to-clear strobes
    always_comb begin
        clr_lo = 8'h00;
        clr_hi = 8'h00;
        clr_err = 8'h00;
        clr_mf = 2'h0;
        if (wr) begin
            if (paddr == `RFIA_OFS_EVT_FLAGS_LOW) begin
                clr_lo = wb;
            end
            if (paddr == `RFIA_OFS_EVT_FLAGS_HIGH) begin
                clr_hi = wb;
            end
            if (paddr == `RFIA_OFS_ERR_FLAGS) begin
                clr_err = wb;
            end
            if (paddr == `RFIA_OFS_CPU_IF) begin
                clr_mf = wb[1:0];
            end
        end
    end

    // Edges only: a source held high raises one request
    assign rise_lo = event_src_low & ~s.src_lo_q;
    assign rise_hi = event_src_high & ~s.src_hi_q;

    // Buffer misuse reported as error flags
    always_comb begin
        err_set = {error_src, 4'h0};
        err_set[`RFIA_ERR_RX_OVF] = rx_buf_wr & rx_buf_full;
        err_set[`RFIA_ERR_RX_UNF] = rx_buf_rd & rx_buf_empty;
        err_set[`RFIA_ERR_TX_OVF] = tx_buf_wr & tx_buf_full;
        err_set[`RFIA_ERR_TX_UNF] = tx_buf_rd & tx_buf_empty;
    end

    always_comb begin
        n = s;
        n.src_lo_q = event_src_low;
        n.src_hi_q = event_src_high;

        // Set wins over clear; mask plays no part here
        n.flg_lo = (s.flg_lo & ~clr_lo) | rise_lo;
        n.flg_hi = (s.flg_hi & ~clr_hi) | rise_hi;
        n.err = (s.err & ~clr_err) | err_set;

        if (wr) begin
            case (paddr)
                `RFIA_OFS_EVT_MASK_LOW: n.msk_lo = wb;
                `RFIA_OFS_EVT_MASK_HIGH: n.msk_hi = wb;
                `RFIA_OFS_ERR_MASK: n.err_m = wb;
                `RFIA_OFS_CPU_IE: n.ie = wb[1:0];
                default: ;
            endcase
        end

        // Errors feed only vector 0, events only vector 12
        req_err = |(n.err & n.err_m);
        req_evt = |(n.flg_lo & n.msk_lo) | |(n.flg_hi & n.msk_hi);
        n.req = {req_evt, req_err};

        core_clr[`RFIA_VEC_ERR] = |(clr_err & s.err);
        core_clr[`RFIA_VEC_EVT] = |(clr_lo & s.flg_lo) | |(clr_hi & s.flg_hi);

        set_mf = (n.req & ~s.req) | (core_clr & n.req);
        n.mf = (s.mf & ~clr_mf) | set_mf;

        // Level request while main flag stays set, so the handler re-enters
        n.irq_err = n.mf[`RFIA_VEC_ERR] & n.ie[`RFIA_VEC_ERR];
        n.irq_evt = n.mf[`RFIA_VEC_EVT] & n.ie[`RFIA_VEC_EVT];
        n.irq = n.irq_err | n.irq_evt;
        // Error vector reported first when both pend
        if (n.irq_err) begin
            n.vnum = `RFIA_VNUM_ERR;
        end else if (n.irq_evt) begin
            n.vnum = `RFIA_VNUM_EVT;
        end else begin
            n.vnum = `RFIA_VNUM_ERR;
        end

        // One wait state: pready in the second access cycle
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        if (acc && !s.pready) begin
            n.pready = 1'b1;
            n.pslverr = ~hit;
            n.prdata = pwrite ? 32'h0000_0000 : rd_mux;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign radio_error_vector = s.irq_err;
    assign radio_event_vector = s.irq_evt;
    assign irq = s.irq;
    assign irq_vector_num = s.vnum;

    // Helpers for the checks below
    logic wr_lo;
    logic wr_if;
    logic wr_ie;
    assign wr_lo = wr && (paddr == `RFIA_OFS_EVT_FLAGS_LOW);
    assign wr_if = wr && (paddr == `RFIA_OFS_CPU_IF);
    assign wr_ie = wr && (paddr == `RFIA_OFS_CPU_IE);

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    sequence evt_clear_s;
        wr_lo && wb[0] && s.flg_lo[0];
    endsequence

    sequence others_pend_s;
        (s.flg_lo[1] && s.msk_lo[1] && !wb[1])
            || (s.flg_hi[0] && s.msk_hi[0]);
    endsequence

    vec_number_a: assert property (
        irq_vector_num == (radio_error_vector ? 4'h0
            : (radio_event_vector ? 4'hC : 4'h0)))
        else $error("vector number does not match pending vector");

    vec_route_a: assert property (
        $rose(s.mf[1]) |-> s.req[1] || $past(s.mf[1]) == 1'b0
            && |((s.flg_lo & s.msk_lo) | (s.flg_hi & s.msk_hi)))
        else $error("event main flag set without event cause");

    edge_only_a: assert property (
        evt_clear_s ##0 (event_src_low[0] && s.src_lo_q[0])
            |=> !s.flg_lo[0])
        else $error("steady source set its flag again");

    edge_set_a: assert property (
        event_src_low[0] && !s.src_lo_q[0] |=> s.flg_lo[0])
        else $error("rising source did not set its flag");

    mask_write_a: assert property (
        wr && paddr == 8'h0C |=> s.msk_lo == $past(wb))
        else $error("event mask write lost");

    masked_update_a: assert property (
        rx_buf_wr && rx_buf_full && !s.err_m[0]
            |=> s.err[0] && !s.mf[0] || $past(s.mf[0]) || s.req[0])
        else $error("masked flag not updated");

    enable_write_a: assert property (
        wr_ie |=> s.ie == $past(wb[1:0]))
        else $error("vector enable write lost");

    flag_hold_a: assert property (
        s.mf[1] && !wr_if |=> s.mf[1])
        else $error("main flag dropped without a clear");

    rearm_main_a: assert property (
        evt_clear_s ##0 others_pend_s ##0 !(wr_if && wb[1])
            |=> s.mf[1])
        else $error("main flag not set again after core clear");

    reenter_a: assert property (
        s.mf[1] && s.ie[1] && !wr_if && !wr_ie |=> irq && radio_event_vector)
        else $error("pending vector stopped requesting");

    overflow_flag_a: assert property (
        tx_buf_wr && tx_buf_full |=> s.err[2]
            ##0 (s.err_m[2] ? s.req[0] : 1'b1))
        else $error("buffer overflow not flagged");

    main_edge_a: assert property (
        s.req[0] && !$past(s.req[0]) |-> s.mf[0])
        else $error("main flag missed a rising request");

    set_wins_a: assert property (
        wr_lo && wb[2] && event_src_low[2] && !s.src_lo_q[2]
            |=> s.flg_lo[2])
        else $error("clear beat a new event");

    apb_answer_a: assert property (
        psel && penable && !pready |=> pready)
        else $error("access not answered in one wait state");

    err_wins_a: assert property (
        wr && paddr == `RFIA_OFS_ERR_FLAGS && wb[5] && error_src[5] |=> s.err[5])
        else $error("error clear beat a new error event");

    main_wins_a: assert property (
        wr_if && wb[0] && set_mf[0] |=> s.mf[0])
        else $error("main flag clear beat a rising request");

    evt_hold_a: assert property (
        s.flg_lo[1] && !wr_lo |=> s.flg_lo[1])
        else $error("event flag dropped without a clear");

    err_hold_a: assert property (
        s.err[0] && !(wr && paddr == `RFIA_OFS_ERR_FLAGS) |=> s.err[0])
        else $error("error flag dropped without a clear");

    err_main_hold_a: assert property (
        s.mf[0] && !wr_if |=> s.mf[0])
        else $error("error main flag dropped without a clear");

    err_cause_a: assert property (
        $rose(s.mf[0]) |-> |(s.err & s.err_m))
        else $error("error main flag set without error cause");

    err_reenter_a: assert property (
        s.mf[0] && s.ie[0] && !wr_if && !wr_ie |=> irq && radio_error_vector)
        else $error("pending error vector stopped requesting");

    irq_level_a: assert property (
        irq == (s.mf[0] && s.ie[0] || s.mf[1] && s.ie[1]))
        else $error("request does not follow main flags and enables");

    rx_overflow_a: assert property (
        rx_buf_wr && rx_buf_full |=> s.err[`RFIA_ERR_RX_OVF])
        else $error("receive overflow not flagged");

    rx_underflow_a: assert property (
        rx_buf_rd && rx_buf_empty |=> s.err[`RFIA_ERR_RX_UNF])
        else $error("receive underflow not flagged");

    tx_underflow_a: assert property (
        tx_buf_rd && tx_buf_empty |=> s.err[`RFIA_ERR_TX_UNF])
        else $error("transmit underflow not flagged");

    no_false_error_a: assert property (
        !s.err[0] && !(rx_buf_wr && rx_buf_full) |=> !s.err[0])
        else $error("receive overflow flag set without cause");

    evt_combine_a: assert property (
        s.req[1] == (|(s.flg_lo & s.msk_lo) || |(s.flg_hi & s.msk_hi)))
        else $error("event request is not the masked flag OR");

    err_combine_a: assert property (
        s.req[0] == |(s.err & s.err_m))
        else $error("error request is not the masked flag OR");

    apb_pulse_a: assert property (
        pready |=> !pready)
        else $error("ready held longer than one cycle");

    slverr_ready_a: assert property (
        pslverr |-> pready)
        else $error("slave error outside a completion");

    edge_set_high_a: assert property (
        event_src_high[3] && !s.src_hi_q[3] |=> s.flg_hi[3])
        else $error("rising high source did not set its flag");

    main_clear_a: assert property (
        wr_if && wb[1] && !set_mf[1] |=> !s.mf[1])
        else $error("event main flag clear lost");

endmodule
`default_nettype wire

// ---- test/rfia_cpu_model.sv ----
/*
 CPU-side interrupt controller model: counts handler entries per vector.
 Assumes irq and its vector number are registered on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rfia_map.svh"

module rfia_cpu_model (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic irq,
    input wire rfia_pkg::rfia_vnum_t vnum,
    output logic [7:0] n_err,
    output logic [7:0] n_evt
);
    import rfia_pkg::*;
    logic irq_q;
    // Entry taken on each rise of the level request, like a real core
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irq_q <= 1'b0;
            n_err <= 8'h00;
            n_evt <= 8'h00;
        end else begin
            irq_q <= irq;
            if (irq && !irq_q && vnum == `RFIA_VNUM_ERR) begin
                n_err <= n_err + 8'h01;
            end
            if (irq && !irq_q && vnum == `RFIA_VNUM_EVT) begin
                n_evt <= n_evt + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ---- test/test_radio_irq_aggregator.sv ----
/*
 Self-checking bench of the radio interrupt aggregator over APB.
 Assumes rfia_top and rfia_cpu_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rfia_map.svh"

module test_radio_irq_aggregator;
    import rfia_pkg::*;
    logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, err_q;
    logic err_vec, evt_vec, irq;
    logic [7:0] paddr, ev_lo, ev_hi, n_err, n_evt;
    logic [31:0] pwdata, prdata, rd;
    logic [7:4] err_src;
    logic [3:0] stb, lvl;
    rfia_vnum_t vnum;
    int fails, n_tests;

    rfia_top rfia_top_inst (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_src_low(ev_lo), .event_src_high(ev_hi), .error_src(err_src),
        .rx_buf_wr(stb[0]), .rx_buf_rd(stb[1]), .rx_buf_full(lvl[0]), .rx_buf_empty(lvl[1]),
        .tx_buf_wr(stb[2]), .tx_buf_rd(stb[3]), .tx_buf_full(lvl[2]), .tx_buf_empty(lvl[3]),
        .radio_error_vector(err_vec), .radio_event_vector(evt_vec), .irq(irq),
        .irq_vector_num(vnum));
    rfia_cpu_model rfia_cpu_model_inst (.mclk(mclk), .arst_n(arst_n), .irq(irq), .vnum(vnum),
        .n_err(n_err), .n_evt(n_evt));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) fails++;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    task automatic settle;
        repeat (3) @(posedge mclk);
    endtask

    // Packs vector number, error vector, event vector and irq
    task automatic out_chk(input logic [7:0] exp);
        check({24'h0, vnum, 1'b0, err_vec, evt_vec, irq}, {24'h0, exp});
    endtask

    // Main flag first, core flags in one write last
    task automatic handle(input logic [7:0] fa, input logic [31:0] fv, input logic [31:0] mv);
        xfer(1'b1, `RFIA_OFS_CPU_IF, mv);
        xfer(1'b1, fa, fv);
    endtask

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        #50us;
        fails++;
        tally_and_finish();
    end

    initial begin
        {arst_n, psel, penable, pwrite, paddr, pwdata, ev_lo, ev_hi, err_src, stb, lvl} = '0;
        fails = 0;
        n_tests = 0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        for (int a = 0; a < 32; a += 4) rchk(8'(a), 32'h0);
        xfer(1'b0, 8'h20, 32'h0);
        check({31'h0, err_q}, 32'h1);
        $display("test reset done");

        xfer(1'b1, `RFIA_OFS_EVT_MASK_LOW, 32'h03);
        xfer(1'b1, `RFIA_OFS_CPU_IE, 32'h03);
        @(posedge mclk);
        ev_lo <= 8'h01;
        settle();
        out_chk(8'hC3);
        check({24'h0, n_evt}, 32'h1);
        rchk(`RFIA_OFS_EVT_FLAGS_LOW, 32'h01);
        rchk(`RFIA_OFS_CPU_IF, 32'h02);
        handle(`RFIA_OFS_EVT_FLAGS_LOW, 32'h01, 32'h02);
        settle();
        out_chk(8'h00);
        rchk(`RFIA_OFS_EVT_FLAGS_LOW, 32'h00);
        @(posedge mclk);
        ev_lo <= 8'h00;
        @(posedge mclk);
        ev_lo <= 8'h03;
        settle();
        xfer(1'b1, `RFIA_OFS_CPU_IF, 32'h02);
        settle();
        out_chk(8'h00);
        xfer(1'b1, `RFIA_OFS_EVT_FLAGS_LOW, 32'h01);
        settle();
        rchk(`RFIA_OFS_CPU_IF, 32'h02);
        out_chk(8'hC3);
        check({24'h0, n_evt}, 32'h3);
        handle(`RFIA_OFS_EVT_FLAGS_LOW, 32'h02, 32'h02);
        rchk(`RFIA_OFS_CPU_IF, 32'h00);
        $display("test event vector done");

        @(posedge mclk);
        ev_hi <= 8'h08;
        settle();
        rchk(`RFIA_OFS_EVT_FLAGS_HIGH, 32'h08);
        out_chk(8'h00);
        xfer(1'b1, `RFIA_OFS_EVT_MASK_HIGH, 32'h08);
        settle();
        out_chk(8'hC3);
        handle(`RFIA_OFS_EVT_FLAGS_HIGH, 32'h08, 32'h02);
        rchk(`RFIA_OFS_EVT_MASK_HIGH, 32'h08);
        // New event lands on the edge that takes the clear
        fork
            xfer(1'b1, `RFIA_OFS_EVT_FLAGS_LOW, 32'h04);
            begin
                repeat (3) @(posedge mclk);
                ev_lo <= 8'h07;
            end
        join
        rchk(`RFIA_OFS_EVT_FLAGS_LOW, 32'h04);
        xfer(1'b1, `RFIA_OFS_EVT_FLAGS_LOW, 32'h04);
        rchk(`RFIA_OFS_EVT_FLAGS_LOW, 32'h00);
        $display("test masking done");

        // Masked error still sets its flag
        @(posedge mclk);
        stb <= 4'h1;
        lvl <= 4'h1;
        @(posedge mclk);
        stb <= 4'h0;
        settle();
        rchk(`RFIA_OFS_ERR_FLAGS, 32'h01);
        out_chk(8'h00);
        xfer(1'b1, `RFIA_OFS_ERR_FLAGS, 32'h01);
        rchk(`RFIA_OFS_ERR_FLAGS, 32'h00);
        xfer(1'b1, `RFIA_OFS_ERR_MASK, 32'hFF);
        // First pass: strobes with no bad state must stay silent
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 4; i++) begin
                @(posedge mclk);
                stb <= 4'h1 << i;
                lvl <= (k == 1) ? 4'h1 << i : 4'h0;
                @(posedge mclk);
                stb <= 4'h0;
            end
            settle();
            rchk(`RFIA_OFS_ERR_FLAGS, (k == 1) ? 32'h0F : 32'h00);
        end
        @(posedge mclk);
        err_src <= 4'h1;
        @(posedge mclk);
        err_src <= 4'h2;
        xfer(1'b1, `RFIA_OFS_ERR_FLAGS, 32'h3F);
        @(posedge mclk);
        err_src <= 4'h0;
        settle();
        rchk(`RFIA_OFS_ERR_FLAGS, 32'h20);
        out_chk(8'h05);
        check({24'h0, n_err}, 32'h1);
        handle(`RFIA_OFS_ERR_FLAGS, 32'h20, 32'h01);
        settle();
        out_chk(8'h00);
        rchk(`RFIA_OFS_CPU_IF, 32'h00);
        $display("test error vector done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
